// ### spi_pin_config.sv
// Pin, mode fault, serial clock and register logic of the SPI unit.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// RQ1: Master without fault detect ignores select pin.
// RQ2: Slave always takes select pin as input.
// RQ3: Master fault-enable or single-wire change aborts.
// RQ4: Single-wire output enable gates data buffer.
// RQ5: Master single-wire output enable change aborts.
// RQ6: Halt in wait stops serial clock.
// RQ7: Master pins: normal two-wire or MOSI shared.
// RQ8: Slave pins: normal two-wire or MISO shared.
// RQ9: Reserved bit writes change nothing.
// RQ10: Divisor is (pre+1) times 2^(sel+1).
// RQ11: Serial clock is bus clock over divisor.
// RQ12: Divisors 2, 256, 512 at table corners; the code's corners are 2, 16, 256 and 2048.
// RQ13: Master divider field change aborts transfer.
// RQ14: Select output only with both enables.
// RQ15: Select low as master sets conflict flag.
// RQ16: External master never clocks slave at divide-two.
module spi_pin_config
  import spi_cfg_pkg::*;
#(
  parameter int CNT_W = 11  // Width of the divider counter.
) (
  input  wire logic              clk,           // Bus clock, 20 MHz.
  input  wire logic              rst,           // Synchronous reset, active high.
  input  wire logic              psel,          // APB select.
  input  wire logic              penable,       // APB enable.
  input  wire logic              pwrite,        // APB direction, high for write.
  input  wire logic [ADDR_W-1:0] paddr,         // APB byte address.
  input  wire logic [31:0]       pwdata,        // APB write data.
  output logic      [31:0]       prdata,        // APB read data.
  output logic                   pready,        // APB ready.
  output logic                   pslverr,       // APB error on unmapped address.
  output logic                   irq,           // Level interrupt.
  input  wire logic              wait_mode,     // Chip is in wait mode.
  input  wire logic              shift_active,  // Shifter has a transfer in progress.
  input  wire logic              tx_bit,        // Bit the shifter sends.
  output logic                   rx_bit,        // Synchronised bit for the shifter.
  output logic                   rx_clock,      // Synchronised serial clock as slave.
  output logic                   force_idle,    // Pulse that returns the shifter to idle.
  output logic                   sck_edge,      // Pulse on each generated clock edge.
  input  wire logic              ss_i,          // Select pad input.
  output pad_drive_type          ss_pad,        // Select pad drive.
  input  wire logic              sck_i,         // Clock pad input.
  output pad_drive_type          sck_pad,       // Clock pad drive.
  input  wire logic              mosi_i,        // Master-out pad input.
  output pad_drive_type          mosi_pad,      // Master-out pad drive.
  input  wire logic              miso_i,        // Master-in pad input.
  output pad_drive_type          miso_pad       // Master-in pad drive.
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int NPIN = 4;         // Number of synchronised pads.
  localparam int PIN_SS = 0;       // Index of the select pad.
  localparam int PIN_SCK = 1;      // Index of the clock pad.
  localparam int PIN_MOSI = 2;     // Index of the master-out pad.
  localparam int PIN_MISO = 3;     // Index of the master-in pad.

  logic [7:0]       unit_ctl_q;    // Unit control register.
  logic [7:0]       pin_ctl_q;     // Pin and fault control register.
  logic [7:0]       divider_q;     // Serial clock divider register.
  logic [EVT_W-1:0] status_q;      // Sticky event bits.
  logic [EVT_W-1:0] mask_q;        // Event mask.
  logic [31:0]      prdata_q;      // Read data register.
  logic             force_idle_q;  // Abort pulse register.
  clk_state_type    clk_state_q;   // Clock generator state.
  clk_state_type    clk_state_d;   // Next clock generator state.
  pin_cfg_type      cfg;           // Decoded pin settings.
  logic             unit_enable;   // Unit enabled.
  logic             master;        // Unit acts as controller.
  logic             sel_out_en;    // Select output enable.
  logic [NPIN-1:0]  pin_raw;       // Pad inputs.
  logic [NPIN-1:0]  sync1_q;       // First synchroniser stage.
  logic [NPIN-1:0]  sync2_q;       // Second synchroniser stage.
  logic [NPIN-1:0]  sync3_q;       // Third synchroniser stage.
  logic [NPIN-1:0]  pin_q;         // Filtered pad levels.
  logic             wr_en;         // Write taken this cycle.
  logic             setup;         // Setup phase of a transfer.
  logic             mapped;        // Address hits a register.
  logic             wr_pin;        // Write to pin and fault control.
  logic             wr_div;        // Write to the divider.
  logic [7:0]       pin_new;       // Pin control value after a write.
  logic [7:0]       div_new;       // Divider value after a write.
  logic             abort;         // Setting change that aborts a transfer.
  logic             ss_watch;      // Select pin is a fault input.
  logic             conflict;      // Mode fault seen this cycle.
  logic [EVT_W-1:0] events;        // Event set terms.
  logic             gen_run;       // Clock generator counts.
  logic             gen_sck;       // Generated clock level.

  assign unit_enable = unit_ctl_q[BIT_UNIT_ENABLE];
  assign master      = unit_ctl_q[BIT_ROLE_SELECT];
  assign sel_out_en  = unit_ctl_q[BIT_SELECT_OE];
  assign cfg         = '{fault_detect_enable:       pin_ctl_q[BIT_FAULT_DETECT],
                         single_wire_output_enable: pin_ctl_q[BIT_SW_OUT_EN],
                         halt_in_wait:              pin_ctl_q[BIT_HALT_IN_WAIT],
                         single_wire_select:        pin_ctl_q[BIT_SW_SELECT]};

  // ----------------------------------------------------------------
  // Pad synchronisers
  // ----------------------------------------------------------------
  assign pin_raw = {miso_i, mosi_i, sck_i, ss_i};

  // Each pad passes three flip-flops; a change counts once the second and third agree.
  generate
    for (genvar i = 0; i < NPIN; i++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          sync1_q[i] <= 1'b1;
          sync2_q[i] <= 1'b1;
          sync3_q[i] <= 1'b1;
          pin_q[i]   <= 1'b1;
        end
        else
        begin
          sync1_q[i] <= pin_raw[i];
          sync2_q[i] <= sync1_q[i];
          sync3_q[i] <= sync2_q[i];
          if (sync2_q[i] == sync3_q[i])
          begin
            pin_q[i] <= sync3_q[i];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite && mapped;
  assign mapped  = (paddr == ADDR_UNIT_CONTROL) || (paddr == ADDR_PIN_AND_FAULT) ||
                   (paddr == ADDR_CLOCK_DIVIDER) || (paddr == ADDR_EVENT_STATUS) ||
                   (paddr == ADDR_EVENT_MASK);
  assign wr_pin  = wr_en && (paddr == ADDR_PIN_AND_FAULT);
  assign wr_div  = wr_en && (paddr == ADDR_CLOCK_DIVIDER);
  // Reserved bits are masked off so that writing them leaves the state alone.
  assign pin_new = pwdata[7:0] & MASK_PIN_AND_FAULT;  // see RQ9
  assign div_new = pwdata[7:0] & MASK_CLOCK_DIVIDER;  // see RQ9
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_q;

  // Read data are captured in the setup phase and stand through the access phase.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata_q <= '0;
    end
    else if (setup && !pwrite)
    begin
      case (paddr)
        ADDR_UNIT_CONTROL:  prdata_q <= {24'h000000, unit_ctl_q};
        ADDR_PIN_AND_FAULT: prdata_q <= {24'h000000, pin_ctl_q};
        ADDR_CLOCK_DIVIDER: prdata_q <= {24'h000000, divider_q};
        ADDR_EVENT_STATUS:  prdata_q <= {28'h0000000, clk_state_q == CLK_HALTED,
                                         clk_state_q == CLK_RUN, status_q};
        ADDR_EVENT_MASK:    prdata_q <= {30'h00000000, mask_q};
        default:            prdata_q <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Unit control register.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      unit_ctl_q <= RST_UNIT_CONTROL;
    end
    else if (wr_en && paddr == ADDR_UNIT_CONTROL)
    begin
      unit_ctl_q <= pwdata[7:0] & MASK_UNIT_CONTROL;
    end
  end

  // Pin and fault control register.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_ctl_q <= RST_PIN_AND_FAULT;
    end
    else if (wr_pin)
    begin
      pin_ctl_q <= pin_new;
    end
  end

  // Serial clock divider register.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      divider_q <= RST_CLOCK_DIVIDER;
    end
    else if (wr_div)
    begin
      divider_q <= div_new;
    end
  end

  // ----------------------------------------------------------------
  // Abort on setting change
  // ----------------------------------------------------------------
  // Only a real change counts; rewriting the same value keeps the transfer going.
  always_comb
  begin
    abort = 1'b0;
    if (master && wr_pin)
    begin
      if (pin_new[BIT_FAULT_DETECT] != cfg.fault_detect_enable ||
          pin_new[BIT_SW_SELECT] != cfg.single_wire_select)
      begin
        abort = 1'b1;  // see RQ3
      end
      else if (cfg.single_wire_select && pin_new[BIT_SW_OUT_EN] != cfg.single_wire_output_enable)
      begin
        abort = 1'b1;  // see RQ5
      end
    end
    if (master && wr_div && div_new != divider_q)
    begin
      abort = 1'b1;  // see RQ13
    end
  end

  // Registered abort pulse; it also restarts the clock generator.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      force_idle_q <= 1'b0;
    end
    else
    begin
      force_idle_q <= abort || (master && conflict);
    end
  end

  assign force_idle = force_idle_q;

  // ----------------------------------------------------------------
  // Select pin and mode fault
  // ----------------------------------------------------------------
  // As master the pin is a fault input with detection on, output off.
  assign ss_watch = unit_enable && master && cfg.fault_detect_enable && !sel_out_en;  // see RQ14
  // A low select level seen by a master that watches the pin is a second master.
  assign conflict = ss_watch && !pin_q[PIN_SS];  // see RQ15

  // Select pad: driven only as master with both enables, else never driven.
  always_comb
  begin
    ss_pad = '{o: 1'b1, oe_n: 1'b1};  // see RQ1
    if (unit_enable && master && cfg.fault_detect_enable && sel_out_en)
    begin
      ss_pad = '{o: !shift_active, oe_n: 1'b0};  // see RQ14
    end
  end

  // ----------------------------------------------------------------
  // Data pins
  // ----------------------------------------------------------------
  // Pad directions follow role, single wire select and its output enable.
  always_comb
  begin
    mosi_pad = '{o: 1'b0, oe_n: 1'b1};
    miso_pad = '{o: 1'b0, oe_n: 1'b1};
    rx_bit   = 1'b0;
    if (unit_enable && master)
    begin
      mosi_pad.o = tx_bit;
      if (!cfg.single_wire_select)
      begin
        mosi_pad.oe_n = 1'b0;  // see RQ7
        rx_bit        = pin_q[PIN_MISO];
      end
      else
      begin
        mosi_pad.oe_n = !cfg.single_wire_output_enable;  // see RQ4
        rx_bit        = pin_q[PIN_MOSI];  // see RQ7
      end
    end
    else if (unit_enable)
    begin
      // A slave drives only while selected.
      miso_pad.o = tx_bit;
      if (!cfg.single_wire_select)
      begin
        miso_pad.oe_n = pin_q[PIN_SS];  // see RQ2
        rx_bit        = pin_q[PIN_MOSI];  // see RQ8
      end
      else
      begin
        miso_pad.oe_n = pin_q[PIN_SS] || !cfg.single_wire_output_enable;  // see RQ4
        rx_bit        = pin_q[PIN_MISO];  // see RQ8
      end
    end
  end

  // Filtered external clock for a slave.
  assign rx_clock = pin_q[PIN_SCK];  // see RQ16

  // ----------------------------------------------------------------
  // Serial clock generation
  // ----------------------------------------------------------------
  // The generator runs in a master transfer, held in wait if asked.
  always_comb
  begin
    clk_state_d = clk_state_q;
    case (clk_state_q)
      CLK_IDLE:
        if (unit_enable && master && shift_active && !force_idle_q)
        begin
          clk_state_d = (cfg.halt_in_wait && wait_mode) ? CLK_HALTED : CLK_RUN;  // see RQ6
        end
      CLK_RUN:
        if (!(unit_enable && master && shift_active) || force_idle_q)
        begin
          clk_state_d = CLK_IDLE;
        end
        else if (cfg.halt_in_wait && wait_mode)
        begin
          clk_state_d = CLK_HALTED;  // see RQ6
        end
      CLK_HALTED:
        if (!(unit_enable && master && shift_active) || force_idle_q)
        begin
          clk_state_d = CLK_IDLE;
        end
        else if (!(cfg.halt_in_wait && wait_mode))
        begin
          clk_state_d = CLK_RUN;
        end
      default:
        clk_state_d = CLK_IDLE;
    endcase
  end

  // Clock generator state register.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clk_state_q <= CLK_IDLE;
    end
    else
    begin
      clk_state_q <= clk_state_d;
    end
  end

  assign gen_run = (clk_state_q == CLK_RUN);

  // Divider that turns the bus clock into the serial clock.
  spi_baud_gen #(
    .CNT_W (CNT_W)
  ) u_baud (
    .clk       (clk),
    .rst       (rst),
    .run       (gen_run),
    .clear     (force_idle_q),
    .preselect (divider_q[LSB_PRESELECT +: BAUD_FIELD_W]),
    .select    (divider_q[LSB_CLOCK_SELECT +: BAUD_FIELD_W]),
    .sck       (gen_sck),
    .edge_p    (sck_edge)
  );

  // Only a master drives the clock pad.
  assign sck_pad = '{o: gen_sck, oe_n: !(unit_enable && master)};

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  assign events = {abort, conflict};

  // Sticky bits cleared by writing one; a new event in the same cycle wins over the clear.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_q <= '0;
    end
    else
    begin
      status_q <= (status_q & ~((wr_en && paddr == ADDR_EVENT_STATUS) ? pwdata[EVT_W-1:0] : '0)) |
                  events;
    end
  end

  // Event mask register.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mask_q <= '0;
    end
    else if (wr_en && paddr == ADDR_EVENT_MASK)
    begin
      mask_q <= pwdata[EVT_W-1:0];
    end
  end

  assign irq = |(status_q & mask_q);
endmodule : spi_pin_config
`default_nettype wire

// ### spi_cfg_pkg.sv
// Register map, fields and carrier types of the SPI configuration block.
package spi_cfg_pkg;
  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam int          IDX_UNIT_CONTROL       = 0;  // Unit control register index.
  localparam int          IDX_PIN_AND_FAULT      = 1;  // Pin and fault control register index.
  localparam int          IDX_CLOCK_DIVIDER      = 2;  // Serial clock divider register index.
  localparam int          IDX_EVENT_STATUS       = 3;  // Event status register index.
  localparam int          IDX_EVENT_MASK         = 4;  // Event mask register index.
  localparam int          ADDR_W                 = 8;  // Width of the bus address.
  localparam logic [7:0]  ADDR_UNIT_CONTROL      = 8'(4 * IDX_UNIT_CONTROL);
  localparam logic [7:0]  ADDR_PIN_AND_FAULT     = 8'(4 * IDX_PIN_AND_FAULT);
  localparam logic [7:0]  ADDR_CLOCK_DIVIDER     = 8'(4 * IDX_CLOCK_DIVIDER);
  localparam logic [7:0]  ADDR_EVENT_STATUS      = 8'(4 * IDX_EVENT_STATUS);
  localparam logic [7:0]  ADDR_EVENT_MASK        = 8'(4 * IDX_EVENT_MASK);

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_UNIT_ENABLE   = 0;  // Unit control: unit enable.
  localparam int BIT_ROLE_SELECT   = 1;  // Unit control: controller role select.
  localparam int BIT_SELECT_OE     = 2;  // Unit control: select output enable.
  localparam int BIT_FAULT_DETECT  = 4;  // Pin and fault control: fault detect enable.
  localparam int BIT_SW_OUT_EN     = 3;  // Pin and fault control: single wire output enable.
  localparam int BIT_HALT_IN_WAIT  = 1;  // Pin and fault control: halt in wait.
  localparam int BIT_SW_SELECT     = 0;  // Pin and fault control: single wire select.
  localparam int LSB_CLOCK_SELECT  = 0;  // Divider: lowest bit of the select field.
  localparam int LSB_PRESELECT     = 4;  // Divider: lowest bit of the preselect field.
  localparam int BAUD_FIELD_W      = 3;  // Width of both divider fields.
  localparam int EVT_CONFLICT      = 0;  // Status: master conflict flag.
  localparam int EVT_ABORT         = 1;  // Status: transfer aborted by a setting change.
  localparam int STS_CLOCK_RUN     = 2;  // Status: serial clock running.
  localparam int STS_WAIT_HALT     = 3;  // Status: clock held by wait mode.
  localparam int EVT_W             = 2;  // Number of sticky event bits.

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_UNIT_CONTROL   = 8'h00;  // Unit control after reset.
  localparam logic [7:0] RST_PIN_AND_FAULT  = 8'h00;  // Pin and fault control after reset.
  localparam logic [7:0] RST_CLOCK_DIVIDER  = 8'h00;  // Divider after reset.
  localparam logic [7:0] MASK_UNIT_CONTROL  = 8'h07;  // Implemented unit control bits.
  localparam logic [7:0] MASK_PIN_AND_FAULT = 8'h1B;  // Implemented pin and fault bits.
  localparam logic [7:0] MASK_CLOCK_DIVIDER = 8'h77;  // Implemented divider bits.

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // Drive of one pad: output value and active-low output enable.
  typedef struct packed {
    logic o;     // Value driven on the pad.
    logic oe_n;  // Low while the pad is driven.
  } pad_drive_type;

  // Decoded settings of the pin and fault control register.
  typedef struct packed {
    logic fault_detect_enable;        // Select pin watched for a second master.
    logic single_wire_output_enable;  // Output buffer on in single wire mode.
    logic halt_in_wait;               // Serial clock stops in wait mode.
    logic single_wire_select;         // One data pin used both ways.
  } pin_cfg_type;

  // Serial clock generator states, Gray coded along idle, run, halted.
  typedef enum logic [1:0] {
    CLK_IDLE   = 2'b00,
    CLK_RUN    = 2'b01,
    CLK_HALTED = 2'b11
  } clk_state_type;
endpackage : spi_cfg_pkg

// ### spi_baud_gen.sv
// Serial clock divider that turns the bus clock into the serial clock.
`timescale 1ns/1ns
`default_nettype none
module spi_baud_gen
  import spi_cfg_pkg::*;
#(
  parameter int CNT_W = 11  // Width of the half period counter.
) (
  input  wire logic                    clk,        // Bus clock.
  input  wire logic                    rst,        // Synchronous reset, active high.
  input  wire logic                    run,        // Count while high.
  input  wire logic                    clear,      // Restart from the idle level.
  input  wire logic [BAUD_FIELD_W-1:0] preselect,  // Preselect field.
  input  wire logic [BAUD_FIELD_W-1:0] select,     // Select field.
  output logic                         sck,        // Serial clock level, low when idle.
  output logic                         edge_p      // One cycle pulse on each serial clock edge.
);
  // ----------------------------------------------------------------
  // Half period
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] half_len;  // Bus cycles per serial clock half period.
  logic [CNT_W-1:0] cnt_q;     // Cycles counted in the current half period.
  logic             sck_q;     // Serial clock level.

  // A half of the divisor (preselect+1) * 2^(select+1).
  assign half_len = CNT_W'({1'b0, preselect} + 4'h1) << select;  // see RQ10

  // ----------------------------------------------------------------
  // Counter and clock level
  // ----------------------------------------------------------------
  // The level toggles after each half period.
  always_ff @(posedge clk)
  begin
    if (rst || clear || !run)
    begin
      cnt_q <= '0;
      sck_q <= 1'b0;
    end
    else if (cnt_q == half_len - CNT_W'(1))
    begin
      cnt_q <= '0;
      sck_q <= ~sck_q;  // see RQ11
    end
    else
    begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Zero fields give a half of one cycle: divisor 2.
  assign edge_p = run && !clear && (cnt_q == half_len - CNT_W'(1));  // see RQ12
  assign sck    = sck_q;
endmodule : spi_baud_gen
`default_nettype wire

// ### spi_pin_config_sva.sv
// Port assertions of the SPI pin configuration block.
`timescale 1ns/1ns
`default_nettype none
module spi_pin_config_sva import spi_cfg_pkg::*; (
  input wire logic clk, rst, psel, penable, pwrite, wait_mode, shift_active, sck_edge, force_idle,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire pad_drive_type ss_pad, mosi_pad, miso_pad
);
  logic [7:0] ctl_q, pf_q, div_q;  // Shadows of the writable registers.
  wire wr = psel && penable && pwrite, mst = ctl_q[1:0] == 2'b11, slv = ctl_q[1:0] == 2'b01;
  // Shadows follow writes.
  always_ff @(posedge clk)
    if (rst) {ctl_q, pf_q, div_q} <= '0;
    else if (wr && paddr == 8'h00) ctl_q <= pwdata[7:0] & 8'h07;
    else if (wr && paddr == 8'h04) pf_q <= pwdata[7:0] & 8'h1B;
    else if (wr && paddr == 8'h08) div_q <= pwdata[7:0] & 8'h77;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_ss_out; !ss_pad.oe_n |-> mst && ctl_q[2] && pf_q[4]; endproperty
  a_ss_out: assert property (p_ss_out) else $error("select driven");
  property p_ss_unused; mst && !pf_q[4] |-> ss_pad.oe_n; endproperty
  a_ss_unused: assert property (p_ss_unused) else $error("select not released");
  property p_ss_slave; slv |-> ss_pad.oe_n; endproperty
  a_ss_slave: assert property (p_ss_slave) else $error("slave drives select");
  property p_mst_pins; mst && !pf_q[0] |-> !mosi_pad.oe_n && miso_pad.oe_n; endproperty
  a_mst_pins: assert property (p_mst_pins) else $error("master pads");
  property p_mst_sw; mst && pf_q[0] |-> mosi_pad.oe_n == !pf_q[3] && miso_pad.oe_n; endproperty
  a_mst_sw: assert property (p_mst_sw) else $error("single wire pads");
  property p_slv_pins; slv |-> mosi_pad.oe_n; endproperty
  a_slv_pins: assert property (p_slv_pins) else $error("slave mosi driven");
  property p_div_abort; wr && mst && paddr == 8'h08 && (pwdata[7:0] & 8'h77) != div_q |-> ##[1:2] force_idle; endproperty
  a_div_abort: assert property (p_div_abort) else $error("no divider abort");
  property p_pin_abort; wr && mst && paddr == 8'h04 && ((pwdata[7:0] ^ pf_q) & 8'h11) != 0 |-> ##[1:2] force_idle;
  endproperty
  a_pin_abort: assert property (p_pin_abort) else $error("no pin abort");
  property p_div2; mst && div_q == 8'h00 && sck_edge && shift_active && !wait_mode && !force_idle
    |=> sck_edge || wait_mode || force_idle || !shift_active; endproperty
  a_div2: assert property (p_div2) else $error("edge missed");
  property p_halt; pf_q[1] && wait_mode && $past(wait_mode) && $past(wait_mode, 2) |-> !sck_edge; endproperty
  a_halt: assert property (p_halt) else $error("clock ran in wait");
  c_abort: cover property (force_idle);
  c_halt: cover property (pf_q[1] && wait_mode && shift_active);
  c_sw: cover property (mst && pf_q[0] && pf_q[3]);
endmodule : spi_pin_config_sva
`default_nettype wire

// ### spi_peer.sv
// Behavioural external SPI peripheral on the four pads.
`timescale 1ns/1ns
`default_nettype none
module spi_peer import spi_cfg_pkg::*; (
  input wire logic fault,  // Second master pulls select low.
  input wire pad_drive_type ss_pad, sck_pad, mosi_pad, miso_pad,
  output logic ss_i, sck_i, mosi_i, miso_i
);
  logic [7:0] sh_q = 8'hA5;  // Peripheral shift register.
  // Select pulls up; the peer never clocks itself, so never at divide two.
  assign ss_i = fault ? 1'b0 : (ss_pad.oe_n ? 1'b1 : ss_pad.o);
  assign sck_i = sck_pad.oe_n ? 1'b0 : sck_pad.o;
  assign mosi_i = mosi_pad.oe_n ? ~sh_q[0] : mosi_pad.o;
  assign miso_i = miso_pad.oe_n ? sh_q[7] : miso_pad.o;
  always @(posedge sck_i) sh_q <= {sh_q[6:0], mosi_i};
endmodule : spi_peer
`default_nettype wire

// ### spi_pin_config_tb.sv
// Self-checking bench of the SPI pin configuration block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("unexpected %0t %h %h", $time, g, e); end end
module spi_pin_config_tb import spi_cfg_pkg::*; ;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, wait_mode = 0, shift_active = 0, tx_bit = 0, fault = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 0, prdata, r, rs = 3039;
  logic pready, pslverr, irq, rx_bit, rx_clock, force_idle, sck_edge, ss_i, sck_i, mosi_i, miso_i, perr;
  pad_drive_type ss_pad, sck_pad, mosi_pad, miso_pad;
  int num_errors = 0, compares = 0, n, m[8], msk[5] = '{'h07, 'h1B, 'h77, 0, 'h03};
  spi_pin_config dut (.*);
  spi_peer peer (.*);
  always #25 clk = ~clk;
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  task automatic apb(input logic w, input int i, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 8'(4 * i), d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    {r, perr} = {prdata, pslverr};
    {psel, penable, tx_bit} <= {2'b00, rs[0]};
  endtask : apb
  // Writes also update the model.
  task automatic wr(input int i, input logic [31:0] d);
    int o = m[i];
    apb(1, i, d);
    if (i == 3) m[3] &= ~d;
    else if (i < 5) m[i] = d & msk[i];
    if (m[0][1:0] == 2'b11 && ((i == 2 && o != m[2]) || (i == 1 && ((o ^ m[1]) & (o[0] ? 'h19 : 'h11)) != 0))) m[3] |= 2;
  endtask : wr
  task automatic rd(input int i, input logic [31:0] k);
    apb(0, i, 0);
    `CHK(r & k, m[i] & k)
    `CHK(perr, i > 4)
  endtask : rd
  task automatic ichk();
    @(negedge clk);
    `CHK(irq, (m[3] & m[4]) != 0)
  endtask : ichk
  task automatic give_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    #2000000 num_errors++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 6; i++) rd(i, '1);
    repeat (6) begin wr(1, rnd()); wr(2, rnd()); wr(5, rnd()); rd(1, '1); rd(2, '1); rd(5, '1); end
    for (int c = 0; c < 8; c++) begin
      wr(0, 1 | c[0] << 1 | c[2] << 2);
      wr(1, c[1] << 4 | c[2] << 3 | c[1]);
      @(negedge clk);
      `CHK(mosi_pad.oe_n, c[0] ? (c[1] & !c[2]) : 1'b1)
      `CHK(ss_pad.oe_n, !(c[0] & c[1] & c[2]))
      rd(3, 3);
    end
    wr(3, 3);
    wr(1, 0);
    for (int c = 0; c < 4; c++) begin
      n = c == 3 ? rnd() & 'h77 : (c & 1) << 4 | (c ? 7 : 0);
      wr(2, n);
      shift_active <= 1;
      do @(negedge clk); while (sck_edge !== 1);
      r = 0;
      do begin @(negedge clk); r++; end while (sck_edge !== 1);
      `CHK(2 * r, (n[6:4] + 1) * 2 ** (n[2:0] + 1))
      @(posedge clk) shift_active <= 0;
    end
    wr(4, 2);
    ichk();
    wr(3, 2);
    ichk();
    wr(0, 3);
    wr(1, 'h12);
    {shift_active, wait_mode} <= 2'b11;
    repeat (2) @(posedge clk);
    apb(0, 3, 0);
    `CHK(r[3:2], 2'b10)
    wait_mode <= 0;
    apb(0, 3, 0);
    `CHK(r[3:2], 2'b01)
    fault <= 1;
    repeat (6) @(posedge clk);
    fault <= 0;
    m[3] |= 1;
    rd(3, 3);
    give_verdict();
  end
endmodule : spi_pin_config_tb
bind spi_pin_config spi_pin_config_sva chk (.*);
`default_nettype wire
